// file: core/srx_pkg.sv
// Purpose: constants and types for the synchronous exception router
// Assumes: one core clock, AXI4-Lite register access
// Notes: level and cause codes are shared with the pipeline
package srx_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int VA_W = 32;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RET = 8'h08;
   localparam logic [7:0] OFS_FAULT = 8'h0c;
   // ---------------------------------------------------------------
   // control field positions
   // ---------------------------------------------------------------
   localparam int B_ROUTE_USER_TO_HYP = 0;
   localparam int B_HYP_CALL_ENABLE = 1;
   localparam int B_USER_STACK_CHECK = 2;
   localparam int B_KSTACK_CHECK = 3;
   localparam int B_HSTACK_CHECK = 4;
   localparam int B_MSTACK_CHECK = 5;
   localparam int B_HYP_IMPL = 6;
   localparam int B_MON_IMPL = 7;
   localparam int B_SEC_HYP_EN = 8;
   localparam int CTRL_W = 9;
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h0c0;
   // ---------------------------------------------------------------
   // status field positions
   // ---------------------------------------------------------------
   localparam int S_LEVEL_LO = 0;
   localparam int S_CAUSE_LO = 4;
   localparam int S_COUNT_LO = 16;
   // ---------------------------------------------------------------
   // fixed implementation choices
   // ---------------------------------------------------------------
   localparam logic TRAP_COND_FAIL = 1'b0;
   localparam logic TRAP_UNPREDICTABLE = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LVL_USER = 2'h0, LVL_KERNEL = 2'h1, LVL_HYP = 2'h2, LVL_MONITOR = 2'h3
   } srx_level_t;
   typedef enum logic [3:0] {
      C_NONE = 4'h0, C_PC_ALIGN = 4'h1, C_HIGHER = 4'h2, C_UNDEF = 4'h3,
      C_SVC = 4'h4, C_HVC = 4'h5, C_SMC = 4'h6, C_TRAP = 4'h7, C_SP_ALIGN = 4'h8
   } srx_cause_t;
   typedef enum logic [2:0] {
      I_NORMAL = 3'h0, I_UNDEF = 3'h1, I_SVC = 3'h2, I_HVC = 3'h3,
      I_SMC = 3'h4, I_PREFETCH = 3'h5, I_LDST = 3'h6
   } srx_iclass_t;
endpackage

// file: core/srx_router.sv
// Purpose: decide synchronous exceptions, their target level, and interrupt taking
// Assumes: pipeline inputs share aclk; one instruction offered per valid cycle
// Notes: all outputs registered; registers on AXI4-Lite
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module srx_router
   import srx_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic instr_valid,
   input wire logic [2:0] instr_class,
   input wire logic [1:0] cur_level,
   input wire logic exec_64,
   input wire logic secure,
   input wire logic [srx_pkg::VA_W-1:0] pc,
   input wire logic [srx_pkg::VA_W-1:0] sp,
   input wire logic sp_base,
   input wire logic cond_fail,
   input wire logic unpredictable,
   input wire logic higher_fault,
   input wire logic trap_kernel,
   input wire logic trap_hyp,
   input wire logic trap_monitor,
   input wire logic irq_pending,
   input wire logic irq_unmasked,
   input wire logic multi_access,
   output logic exc_valid,
   output logic [1:0] exc_level,
   output logic [3:0] exc_cause,
   output logic [srx_pkg::VA_W-1:0] exc_ret_addr,
   output logic [srx_pkg::VA_W-1:0] exc_fault_addr,
   output logic instr_commit,
   output logic irq_take,
   input wire logic [srx_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [srx_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [srx_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [srx_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import srx_pkg::*;

   // ---------------------------------------------------------------
   // control bits
   // ---------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_r;
   logic tge_eff;
   logic hyp_en_cur;
   logic stack_chk;
   logic [1:0] user_tgt;
   logic [11:0] exc_count_r;

   assign tge_eff = ctrl_r[B_ROUTE_USER_TO_HYP] & ctrl_r[B_HYP_IMPL];
   assign hyp_en_cur = ctrl_r[B_HYP_IMPL] & (~secure | ctrl_r[B_SEC_HYP_EN]);
   assign user_tgt = tge_eff ? LVL_HYP : LVL_KERNEL;

   always_comb begin
      unique case (cur_level)
         LVL_USER: stack_chk = ctrl_r[B_USER_STACK_CHECK];
         LVL_KERNEL: stack_chk = ctrl_r[B_KSTACK_CHECK];
         LVL_HYP: stack_chk = ctrl_r[B_HSTACK_CHECK];
         LVL_MONITOR: stack_chk = ctrl_r[B_MSTACK_CHECK];
      endcase
   end

   // ---------------------------------------------------------------
   // cause detection
   // ---------------------------------------------------------------
   logic pc_mis;
   logic sp_mis;
   logic hvc_undef;
   logic smc_undef;
   logic is_undef;
   logic trap_ok;
   logic trap_k_eff;
   logic trap_h_eff;
   logic trap_m_eff;

   assign pc_mis = pc[1:0] != 2'h0;
   assign sp_mis = sp_base && (instr_class == I_LDST) && stack_chk
                   && (sp[3:0] != 4'h0);
   assign hvc_undef = (cur_level == LVL_USER) || ~ctrl_r[B_HYP_CALL_ENABLE]
                      || ((cur_level == LVL_KERNEL) && ~hyp_en_cur);
   assign smc_undef = (cur_level == LVL_USER) || ~ctrl_r[B_MON_IMPL];
   assign is_undef = (instr_class == I_UNDEF)
                     || ((instr_class == I_HVC) && hvc_undef)
                     || ((instr_class == I_SMC) && smc_undef);
   assign trap_ok = (exec_64 || ~cond_fail || TRAP_COND_FAIL)
                    && (~unpredictable || TRAP_UNPREDICTABLE);
   assign trap_k_eff = trap_kernel;
   assign trap_h_eff = trap_hyp && hyp_en_cur;
   assign trap_m_eff = trap_monitor && ctrl_r[B_MON_IMPL];

   // ---------------------------------------------------------------
   // priority select
   // ---------------------------------------------------------------
   logic [3:0] cause_nxt;
   logic [1:0] level_nxt;
   logic [1:0] cur_tgt;

   assign cur_tgt = (cur_level == LVL_USER) ? user_tgt : cur_level;

   always_comb begin
      cause_nxt = C_NONE;
      level_nxt = cur_tgt;
      if (pc_mis) begin
         cause_nxt = C_PC_ALIGN;
      end else if (higher_fault) begin
         cause_nxt = C_HIGHER;
      end else if (is_undef) begin
         cause_nxt = C_UNDEF;
      end else if (instr_class == I_SVC) begin
         cause_nxt = C_SVC;
      end else if (instr_class == I_HVC) begin
         cause_nxt = C_HVC;
         level_nxt = (cur_level == LVL_MONITOR) ? LVL_MONITOR : LVL_HYP;
      end else if (instr_class == I_SMC) begin
         cause_nxt = C_SMC;
         level_nxt = LVL_MONITOR;
      end else if (trap_ok && trap_m_eff) begin
         cause_nxt = C_TRAP;
         level_nxt = LVL_MONITOR;
      end else if (trap_ok && trap_h_eff && (cur_level != LVL_MONITOR)) begin
         cause_nxt = C_TRAP;
         level_nxt = LVL_HYP;
      end else if (trap_ok && trap_k_eff && cur_level[1] == 1'b0) begin
         cause_nxt = C_TRAP;
      end else if (sp_mis) begin
         cause_nxt = C_SP_ALIGN;
      end
   end

   // ---------------------------------------------------------------
   // exception strobe and commit
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exc_valid <= 1'b0;
         exc_level <= LVL_USER;
         exc_cause <= C_NONE;
         exc_ret_addr <= '0;
         exc_fault_addr <= '0;
         instr_commit <= 1'b0;
      end else begin
         exc_valid <= instr_valid && (cause_nxt != C_NONE);
         instr_commit <= instr_valid && (cause_nxt == C_NONE);
         if (instr_valid && (cause_nxt != C_NONE)) begin
            exc_level <= level_nxt;
            exc_cause <= cause_nxt;
            exc_ret_addr <= pc;
            exc_fault_addr <= (cause_nxt == C_PC_ALIGN) ? pc : sp;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exc_count_r <= '0;
      end else if (instr_valid && (cause_nxt != C_NONE)) begin
         exc_count_r <= exc_count_r + 12'h001;
      end
   end

   // ---------------------------------------------------------------
   // interrupt taking
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_take <= 1'b0;
      end else begin
         irq_take <= irq_pending && irq_unmasked
                     && (exec_64 || ~multi_access);
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite write
   // ---------------------------------------------------------------
   logic aw_have_r;
   logic w_have_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [DATA_W-1:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_go;

   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_go) begin
         aw_have_r <= 1'b0;
      end else if (!aw_have_r && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (wr_go) begin
         w_have_r <= 1'b0;
      end else if (!w_have_r && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr_r[7:2] == OFS_CTRL[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_go && (aw_addr_r[7:2] == OFS_CTRL[7:2])) begin
         if (w_strb_r[0]) begin
            ctrl_r[7:0] <= w_data_r[7:0];
         end
         if (w_strb_r[1]) begin
            ctrl_r[8] <= w_data_r[8];
         end
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;
   logic rd_hit;

   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      unique case (s_axi_araddr[7:2])
         OFS_CTRL[7:2]: rd_mux[CTRL_W-1:0] = ctrl_r;
         OFS_STATUS[7:2]: begin
            rd_mux[S_LEVEL_LO +: 2] = exc_level;
            rd_mux[S_CAUSE_LO +: 4] = exc_cause;
            rd_mux[S_COUNT_LO +: 12] = exc_count_r;
         end
         OFS_RET[7:2]: rd_mux = exc_ret_addr;
         OFS_FAULT[7:2]: rd_mux = exc_fault_addr;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_pc_bad;
      instr_valid && (pc[1:0] != 2'h0);
   endsequence
   sequence s_pc_fault_out;
      exc_valid && (exc_cause == C_PC_ALIGN);
   endsequence

   a_pc_align_fault: assert property (s_pc_bad |=> s_pc_fault_out)
      else $error("misaligned pc did not raise pc fault");
   a_pc_fault_addr: assert property (s_pc_bad |=> exc_ret_addr == $past(pc)
      && exc_fault_addr == $past(pc))
      else $error("pc fault addresses differ from pc");
   a_user_undef_route: assert property (instr_valid && instr_class == I_UNDEF
      && cur_level == LVL_USER && pc[1:0] == 2'h0 && !higher_fault
      |=> exc_cause == C_UNDEF
      && exc_level == ($past(tge_eff) ? LVL_HYP : LVL_KERNEL))
      else $error("undefined routing wrong");
   a_no_hyp_route: assert property (!ctrl_r[B_HYP_IMPL] && instr_valid
      && cur_level == LVL_USER && pc[1:0] != 2'h0 |=> exc_level == LVL_KERNEL)
      else $error("user fault routed to hyp without hyp");
   a_svc_route: assert property (instr_valid && instr_class == I_SVC
      && cur_level != LVL_USER && pc[1:0] == 2'h0 && !higher_fault
      |=> exc_cause == C_SVC && exc_level == $past(cur_level))
      else $error("supervisor call not at current level");
   a_hvc_user_undef: assert property (instr_valid && instr_class == I_HVC
      && cur_level == LVL_USER && pc[1:0] == 2'h0 && !higher_fault
      |=> exc_cause == C_UNDEF)
      else $error("user hypervisor call not undefined");
   a_smc_target: assert property (instr_valid && instr_class == I_SMC
      && !smc_undef && pc[1:0] == 2'h0 && !higher_fault
      |=> exc_cause == C_SMC && exc_level == LVL_MONITOR)
      else $error("monitor call not sent to monitor");
   a_prefetch_no_sp: assert property (instr_valid && instr_class == I_PREFETCH
      |=> !(exc_valid && exc_cause == C_SP_ALIGN))
      else $error("prefetch hint raised sp fault");
   a_sp_align_fault: assert property (instr_valid && instr_class == I_LDST
      && sp_base && stack_chk && sp[3:0] != 4'h0 |=> exc_valid)
      else $error("misaligned sp not faulted");
   a_strobe_commit: assert property (instr_valid |=> exc_valid ^ instr_commit)
      else $error("exception and commit not exclusive");
   a_higher_wins: assert property (instr_valid && higher_fault && pc[1:0] == 2'h0
      |=> exc_cause == C_HIGHER)
      else $error("lower cause replaced higher fault");
   a_irq_cause: assert property (irq_take |-> $past(irq_pending && irq_unmasked))
      else $error("interrupt taken while not pending");
   a_irq_multi32: assert property (irq_take |-> $past(exec_64 || !multi_access))
      else $error("32-bit interrupt taken mid access");
   a_sec_hyp_trap: assert property (instr_valid && secure && !ctrl_r[B_SEC_HYP_EN]
      && !trap_kernel && !trap_monitor && !sp_mis && instr_class == I_NORMAL
      && !higher_fault && pc[1:0] == 2'h0 |=> !exc_valid)
      else $error("hyp trap acted in secure state");
endmodule // srx_router
`default_nettype wire

// file: verification/srx_pipe_model.sv
// Purpose: pipeline side model feeding the exception router
// Assumes: the bench calls its tasks; signals change on rising edges
// Notes: released pc and sp show inverted values
`timescale 1ns/10ps
`default_nettype none
module srx_pipe_model (
   input wire logic aclk,
   output logic instr_valid,
   output logic [2:0] instr_class,
   output logic [1:0] cur_level,
   output logic exec_64,
   output logic secure,
   output logic [31:0] pc,
   output logic [31:0] sp,
   output logic sp_base,
   output logic cond_fail,
   output logic unpredictable,
   output logic higher_fault,
   output logic trap_kernel,
   output logic trap_hyp,
   output logic trap_monitor,
   output logic irq_pending,
   output logic irq_unmasked,
   output logic multi_access
);
   initial begin
      {instr_valid, instr_class, cur_level, exec_64, secure} = 8'h00;
      {pc, sp} = 64'h0;
      {sp_base, cond_fail, unpredictable, higher_fault} = 4'h0;
      {trap_kernel, trap_hyp, trap_monitor, irq_pending, irq_unmasked, multi_access} = 6'h00;
   end
   task automatic drive(input logic [2:0] c, input logic [1:0] l, input logic e,
      input logic s, input logic [31:0] p, input logic [31:0] q, input logic [6:0] f);
      @(posedge aclk);
      instr_valid <= 1'b1;
      instr_class <= c;
      cur_level <= l;
      exec_64 <= e;
      secure <= s;
      pc <= p;
      sp <= q;
      {sp_base, cond_fail, unpredictable, higher_fault, trap_kernel, trap_hyp, trap_monitor} <= f;
   endtask
   task automatic idle();
      @(posedge aclk);
      instr_valid <= 1'b0;
      pc <= ~pc;
      sp <= ~sp;
   endtask
   task automatic irq(input logic [3:0] v);
      @(posedge aclk);
      {irq_pending, irq_unmasked, multi_access, exec_64} <= v;
   endtask
endmodule // srx_pipe_model
`default_nettype wire

// file: verification/test_srx_router.sv
// Purpose: self-checking bench for the exception router
// Assumes: pipeline model drives instructions, bench drives AXI4-Lite
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
module test_srx_router;
   import srx_pkg::*;
   logic aclk, aresetn, instr_valid, exec_64, secure, sp_base, cond_fail, unpredictable;
   logic higher_fault, trap_kernel, trap_hyp, trap_monitor, irq_pending, irq_unmasked;
   logic multi_access, exc_valid, instr_commit, irq_take;
   logic [2:0] instr_class;
   logic [1:0] cur_level, exc_level, s_axi_bresp, s_axi_rresp;
   logic [3:0] exc_cause, s_axi_wstrb;
   logic [31:0] pc, sp, exc_ret_addr, exc_fault_addr, s_axi_wdata, s_axi_rdata;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   srx_pipe_model srx_pipe_model_inst (.aclk, .instr_valid, .instr_class, .cur_level,
      .exec_64, .secure, .pc, .sp, .sp_base, .cond_fail, .unpredictable, .higher_fault,
      .trap_kernel, .trap_hyp, .trap_monitor, .irq_pending, .irq_unmasked, .multi_access);
   srx_router srx_router_inst (.aclk, .aresetn, .instr_valid, .instr_class, .cur_level,
      .exec_64, .secure, .pc, .sp, .sp_base, .cond_fail, .unpredictable, .higher_fault,
      .trap_kernel, .trap_hyp, .trap_monitor, .irq_pending, .irq_unmasked, .multi_access,
      .exc_valid, .exc_level, .exc_cause, .exc_ret_addr, .exc_fault_addr, .instr_commit,
      .irq_take, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic ex(input logic [3:0] c, input int l);
      cmp("exc_valid", c != 4'h0, exc_valid);
      cmp("commit", c == 4'h0, instr_commit);
      if (c != 4'h0) cmp("cause", c, exc_cause);
      if (c != 4'h0 && l >= 0) cmp("level", l, exc_level);
   endtask
   task automatic run(input logic [2:0] c, input logic [1:0] l, input logic [3:0] ec,
      input int el, input logic [6:0] f = 7'h0, input logic [31:0] p = 32'h100,
      input logic [31:0] q = 32'h10, input logic e = 1'b1, input logic s = 1'b0);
      srx_pipe_model_inst.drive(c, l, e, s, p, q, f);
      srx_pipe_model_inst.idle();
      #1;
      ex(ec, el);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {ad, wd} = 2'h0;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready === 1'b1) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cmp("bresp", er, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cmp("rdata", e, s_axi_rdata & m);
      cmp("rresp", er, s_axi_rresp);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      cmp("idle strobe", 1'b0, exc_valid);
      rd(OFS_CTRL, 32'h0c0, 32'h1ff, RESP_OKAY);
      rd(8'h10, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(OFS_STATUS, 32'h0, RESP_SLVERR);
      wr(8'h30, 32'h1ff, RESP_SLVERR);
      wr(OFS_CTRL, 32'h1ff, RESP_OKAY);
      rd(OFS_CTRL, 32'h1ff, 32'h1ff, RESP_OKAY);
   endtask
   task automatic t_route();
      int el;
      for (int r = 0; r < 2; r++) begin
         wr(OFS_CTRL, 32'h0fc | r, RESP_OKAY);
         for (int l = 0; l < 4; l++) begin
            el = (l == 0) ? 1 + r : l;
            run(I_UNDEF, l[1:0], C_UNDEF, el);
            run(I_SVC, l[1:0], C_SVC, el);
            run(I_NORMAL, l[1:0], C_PC_ALIGN, el, 7'h0, 32'h101 + (l % 3));
            run(I_LDST, l[1:0], C_SP_ALIGN, el, 7'h40, 32'h10c, 32'h14);
         end
      end
      wr(OFS_CTRL, 32'h081, RESP_OKAY);
      run(I_UNDEF, 2'h0, C_UNDEF, 1);
      run(I_SVC, 2'h0, C_SVC, 1);
      run(I_NORMAL, 2'h0, C_PC_ALIGN, 1, 7'h0, 32'h102);
   endtask
   task automatic t_pcaddr();
      run(I_NORMAL, 2'h1, C_PC_ALIGN, 1, 7'h0, 32'h1002);
      cmp("ret", 32'h1002, exc_ret_addr);
      cmp("fault", 32'h1002, exc_fault_addr);
      rd(OFS_RET, 32'h1002, 32'hffffffff, RESP_OKAY);
      rd(OFS_STATUS, 32'h00240011, 32'h0fff00f3, RESP_OKAY);
   endtask
   task automatic t_stack();
      for (int l = 0; l < 4; l++) begin
         wr(OFS_CTRL, 32'h0c0 | (4 << l), RESP_OKAY);
         for (int m = 0; m < 4; m++) begin
            run(I_LDST, m[1:0], (m == l) ? C_SP_ALIGN : C_NONE, (m == 0) ? 1 : m, 7'h40,
               32'h100, 32'h18);
         end
      end
      wr(OFS_CTRL, 32'h0fc, RESP_OKAY);
      run(I_LDST, 2'h1, C_NONE, 1, 7'h40, 32'h100, 32'h20);
      run(I_LDST, 2'h1, C_SP_ALIGN, 1, 7'h40, 32'h100, 32'h28);
      cmp("fault", 32'h28, exc_fault_addr);
      run(I_PREFETCH, 2'h1, C_NONE, 1, 7'h40, 32'h100, 32'h28);
      run(I_LDST, 2'h1, C_NONE, 1, 7'h0, 32'h100, 32'h28);
   endtask
   task automatic t_calls();
      wr(OFS_CTRL, 32'h0c2, RESP_OKAY);
      run(I_HVC, 2'h1, C_HVC, 2);
      run(I_HVC, 2'h2, C_HVC, 2);
      run(I_HVC, 2'h3, C_HVC, 3);
      run(I_HVC, 2'h0, C_UNDEF, 1);
      run(I_HVC, 2'h1, C_UNDEF, 1, 7'h0, 32'h100, 32'h10, 1'b1, 1'b1);
      wr(OFS_CTRL, 32'h1c2, RESP_OKAY);
      run(I_HVC, 2'h1, C_HVC, 2, 7'h0, 32'h100, 32'h10, 1'b1, 1'b1);
      wr(OFS_CTRL, 32'h0c0, RESP_OKAY);
      run(I_HVC, 2'h1, C_UNDEF, 1);
      run(I_SMC, 2'h1, C_SMC, 3);
      run(I_SMC, 2'h2, C_SMC, 3);
      run(I_SMC, 2'h0, C_UNDEF, 1);
   endtask
   task automatic t_trap();
      run(I_NORMAL, 2'h1, C_TRAP, 1, 7'h04, 32'h300);
      cmp("ret", 32'h300, exc_ret_addr);
      run(I_NORMAL, 2'h1, C_TRAP, 1, 7'h04, 32'h304, 32'h10, 1'b0);
      run(I_NORMAL, 2'h1, C_HIGHER, -1, 7'h0c);
      run(I_NORMAL, 2'h1, C_NONE, 1, 7'h14);
      run(I_NORMAL, 2'h1, C_NONE, 1, 7'h24, 32'h100, 32'h10, 1'b0);
      run(I_NORMAL, 2'h1, C_TRAP, 2, 7'h02);
      run(I_NORMAL, 2'h1, C_NONE, 1, 7'h02, 32'h100, 32'h10, 1'b1, 1'b1);
      wr(OFS_CTRL, 32'h1c0, RESP_OKAY);
      run(I_NORMAL, 2'h1, C_TRAP, 2, 7'h02, 32'h100, 32'h10, 1'b1, 1'b1);
      run(I_NORMAL, 2'h2, C_TRAP, 3, 7'h03);
   endtask
   task automatic t_prio();
      run(I_UNDEF, 2'h1, C_PC_ALIGN, 1, 7'h08, 32'h202);
      run(I_UNDEF, 2'h1, C_HIGHER, 1, 7'h08);
      run(I_SVC, 2'h1, C_SVC, 1, 7'h05);
      run(I_NORMAL, 2'h1, C_TRAP, 3, 7'h45, 32'h100, 32'h18);
      srx_pipe_model_inst.drive(I_UNDEF, 2'h1, 1'b1, 1'b0, 32'h400, 32'h10, 7'h0);
      srx_pipe_model_inst.drive(I_SVC, 2'h1, 1'b1, 1'b0, 32'h404, 32'h10, 7'h0);
      #1;
      ex(C_UNDEF, 1);
      srx_pipe_model_inst.idle();
      #1;
      ex(C_SVC, 1);
   endtask
   task automatic t_irq();
      for (int i = 0; i < 6; i++) begin
         srx_pipe_model_inst.irq(4'(24'hc8ef5d >> (20 - 4 * i)));
         @(posedge aclk);
         #1;
         cmp("irq_take", 6'b100101 >> (5 - i) & 1, irq_take);
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_route();
      t_pcaddr();
      t_stack();
      t_calls();
      t_trap();
      t_prio();
      t_irq();
      results();
   end
endmodule // test_srx_router
`default_nettype wire
